/* File: verilog/clt_defines.svh */
`ifndef CLT_DEFINES_SVH
`define CLT_DEFINES_SVH
// register byte offsets
`define CLT_OFS_CAN 8'h00
`define CLT_OFS_LIN 8'h04
// can register fields
`define CLT_CAN_THERM 0
`define CLT_CAN_DTO 1
`define CLT_CAN_BYP 5
`define CLT_CAN_ACT 7
`define CLT_CAN_MODE_LO 8
`define CLT_CAN_MODE_HI 9
// lin register fields
`define CLT_LIN_THERM 0
`define CLT_LIN_DTO 1
`define CLT_LIN_SHORT 2
`define CLT_LIN_DTO_EN 7
`define CLT_LIN_SHORT_PROTECT_DISABLE_DIS 8
`define CLT_LIN_UV_BYP 9
`define CLT_LIN_BYP 10
`define CLT_LIN_SLOPE_LO 11
`define CLT_LIN_SLOPE_HI 12
`define CLT_LIN_MODE_LO 13
`define CLT_LIN_MODE_HI 14
// codes
`define CLT_MODE_OFF 2'b00
`define CLT_MODE_RX 2'b01
`define CLT_SLOPE_NORMAL 2'b00
`define CLT_SLOPE_SLOW 2'b10
`define CLT_RESET16 16'h0000
`define CLT_HTRANS_NONSEQ 2'b10
`define CLT_HTRANS_SEQ 2'b11
// quiet pin levels: reset and failsafe outputs are active low
`define CLT_EVT_IDLE 10'h005
`define CLT_HSIZE_WORD 3'b010
`define CLT_ADDR_MSB 7
`endif

/* File: verilog/clt_pkg.sv */
package clt_pkg;
	// transceiver mode as driven onto the analog front end
	typedef enum logic [1:0] {
		CLT_TRX_OFF = 2'b00,
		CLT_TRX_RX = 2'b01,
		CLT_TRX_ACTIVE = 2'b10
	} clt_trx_t;
	// hazard inputs after synchronising
	typedef struct packed {
		logic can_thermal;
		logic can_dominant;
		logic lin_thermal;
		logic lin_dominant;
		logic lin_short;
		logic third_supply_undervoltage;
		logic high_side_supply_undervoltage;
		logic reset_output_n;
		logic limp_home_output;
		logic failsafe_output_n;
	} clt_evt_t;
	// transceiver controls
	typedef struct packed {
		clt_trx_t can_mode;
		clt_trx_t lin_mode;
		logic lin_slow_slope;
		logic lin_dominant_timeout_enable;
		logic lin_short_protect_enable;
	} clt_ctl_t;
endpackage

/* File: verilog/clt_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module clt_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_d,
	output logic o_q
);
	logic s1;
	logic s2;
	logic s3;
	// shift chain
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1 <= RESET_LEVEL;
			s2 <= RESET_LEVEL;
			s3 <= RESET_LEVEL;
		end else begin
			s1 <= i_d;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// agreement filter
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_q <= RESET_LEVEL; // idle level, so no false hazard follows reset
		end else if (s2 == s3) begin
			o_q <= s3;
		end
	end
endmodule

/* File: verilog/clt_flag.sv */
`timescale 1ns/1ps
// sticky event flag, write-one clears, a new event wins over the clear
module clt_flag (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_set,
	input wire logic i_clr,
	output logic o_flag
);
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clr) begin
			o_flag <= 1'b0;
		end
	end
endmodule

/* File: verilog/clt_regs.sv */
// Function
// - can mode 00 offline, 01 receive only
// - can mode 10 or 11 active; active mode drops on third supply undervoltage
// - can bypass 0: reset, limp or failsafe output forces can offline
// - bit 7 reads 1 live while can is receive-only or active
// - can thermal flag bit 0 sticky until reset or write one
// - can dominant timeout flag bit 1 sticky until reset or write one
// - flags clear on writing one, writing zero leaves them
// - lin thermal flag bit 0 sticky until reset or write one
// - lin dominant timeout flag bit 1 sticky until reset or write one
// - lin short flag bit 2 sticky until reset or write one
// - lin dominant timeout detection runs only while bit 7 is one
// - lin short protection active while bit 8 is zero
// - bit 9 zero: lin off during high-side supply undervoltage
// - lin bypass 0: reset, limp or failsafe output forces lin offline
// - lin slope 00 normal, 10 slow; 01 and 11 unused
// - lin mode 00 offline, 01 receive only, 10 or 11 active
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "clt_defines.svh"
module clt_regs (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_can_thermal,
	input wire logic i_can_dominant,
	input wire logic i_lin_thermal,
	input wire logic i_lin_dominant,
	input wire logic i_lin_short,
	input wire logic i_third_supply_undervoltage,
	input wire logic i_high_side_supply_undervoltage,
	input wire logic i_reset_output_n,
	input wire logic i_limp_home_output,
	input wire logic i_failsafe_output_n,
	output clt_pkg::clt_ctl_t o_ctl
);
	import clt_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// synchronised hazard inputs
	clt_evt_t raw;
	clt_evt_t evt;
	assign raw = '{can_thermal: i_can_thermal, can_dominant: i_can_dominant,
		lin_thermal: i_lin_thermal, lin_dominant: i_lin_dominant,
		lin_short: i_lin_short,
		third_supply_undervoltage: i_third_supply_undervoltage,
		high_side_supply_undervoltage: i_high_side_supply_undervoltage,
		reset_output_n: i_reset_output_n, limp_home_output: i_limp_home_output,
		failsafe_output_n: i_failsafe_output_n};
	localparam clt_evt_t EVT_IDLE = `CLT_EVT_IDLE;
	genvar g;
	generate
		for (g = 0; g < $bits(clt_evt_t); g++) begin : g_sync
			clt_sync #(.RESET_LEVEL(EVT_IDLE[g])) u_sync (
				.i_clk(i_clk),
				.i_resetn(i_resetn),
				.i_d(raw[g]),
				.o_q(evt[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite address phase capture
	logic wr_pend;
	logic rd_pend;
	logic [`CLT_ADDR_MSB:0] addr_q;
	logic take;
	assign take = i_hsel && i_hready && (i_htrans == `CLT_HTRANS_NONSEQ ||
		i_htrans == `CLT_HTRANS_SEQ);
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q <= '0;
		end else if (i_hready) begin
			wr_pend <= take && i_hwrite;
			rd_pend <= take && !i_hwrite;
			addr_q <= i_haddr[`CLT_ADDR_MSB:0];
		end
	end
	// zero wait states, always okay
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	logic wr_can;
	logic wr_lin;
	assign wr_can = wr_pend && addr_q == `CLT_OFS_CAN;
	assign wr_lin = wr_pend && addr_q == `CLT_OFS_LIN;

	////////////////////////////////////////////////////////////////////////////
	// writable control fields
	logic [1:0] can_mode;
	logic can_safety_offline_bypass;
	logic [1:0] lin_mode;
	logic [1:0] lin_slope;
	logic lin_safety_offline_bypass;
	logic lin_supply_uv_bypass;
	logic lin_short_protect_disable;
	logic lin_dominant_timeout_enable;
	// can control register; unassigned bits are never stored
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			can_mode <= `CLT_MODE_OFF;
			can_safety_offline_bypass <= 1'b0;
		end else if (wr_can) begin
			can_mode <= i_hwdata[`CLT_CAN_MODE_HI:`CLT_CAN_MODE_LO];
			can_safety_offline_bypass <= i_hwdata[`CLT_CAN_BYP];
		end
	end
	// lin control register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lin_mode <= `CLT_MODE_OFF;
			lin_slope <= `CLT_SLOPE_NORMAL;
			lin_safety_offline_bypass <= 1'b0;
			lin_supply_uv_bypass <= 1'b0;
			lin_short_protect_disable <= 1'b0;
			lin_dominant_timeout_enable <= 1'b0;
		end else if (wr_lin) begin
			lin_mode <= i_hwdata[`CLT_LIN_MODE_HI:`CLT_LIN_MODE_LO];
			lin_slope <= i_hwdata[`CLT_LIN_SLOPE_HI:`CLT_LIN_SLOPE_LO];
			lin_safety_offline_bypass <= i_hwdata[`CLT_LIN_BYP];
			lin_supply_uv_bypass <= i_hwdata[`CLT_LIN_UV_BYP];
			lin_short_protect_disable <= i_hwdata[`CLT_LIN_SHORT_PROTECT_DISABLE_DIS];
			lin_dominant_timeout_enable <= i_hwdata[`CLT_LIN_DTO_EN];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky event flags
	logic can_thermal_event_flag;
	logic can_dominant_timeout_flag;
	logic lin_thermal_event_flag;
	logic lin_dominant_timeout_flag;
	logic lin_short_event_flag;
	logic lin_dto_set;
	logic lin_short_protect_disable_set;
	assign lin_dto_set = evt.lin_dominant && lin_dominant_timeout_enable;
	assign lin_short_protect_disable_set = evt.lin_short && !lin_short_protect_disable;
	clt_flag u_can_therm (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_set(evt.can_thermal),
		.i_clr(wr_can && i_hwdata[`CLT_CAN_THERM]),
		.o_flag(can_thermal_event_flag)
	);
	clt_flag u_can_dto (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_set(evt.can_dominant),
		.i_clr(wr_can && i_hwdata[`CLT_CAN_DTO]),
		.o_flag(can_dominant_timeout_flag)
	);
	clt_flag u_lin_therm (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_set(evt.lin_thermal),
		.i_clr(wr_lin && i_hwdata[`CLT_LIN_THERM]),
		.o_flag(lin_thermal_event_flag)
	);
	clt_flag u_lin_dto (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_set(lin_dto_set),
		.i_clr(wr_lin && i_hwdata[`CLT_LIN_DTO]),
		.o_flag(lin_dominant_timeout_flag)
	);
	clt_flag u_lin_short_protect_disable (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_set(lin_short_protect_disable_set),
		.i_clr(wr_lin && i_hwdata[`CLT_LIN_SHORT]),
		.o_flag(lin_short_event_flag)
	);

	////////////////////////////////////////////////////////////////////////////
	// transceiver mode resolution
	logic safety_hit;
	clt_trx_t next_can_trx;
	clt_trx_t next_lin_trx;
	assign safety_hit = !evt.reset_output_n || evt.limp_home_output || !evt.failsafe_output_n;
	always_comb begin
		unique case (can_mode)
			`CLT_MODE_OFF: next_can_trx = CLT_TRX_OFF;
			`CLT_MODE_RX: next_can_trx = CLT_TRX_RX;
			default: next_can_trx = evt.third_supply_undervoltage ? CLT_TRX_OFF :
				CLT_TRX_ACTIVE;
		endcase
		if (safety_hit && !can_safety_offline_bypass) begin
			next_can_trx = CLT_TRX_OFF;
		end
	end
	always_comb begin
		unique case (lin_mode)
			`CLT_MODE_OFF: next_lin_trx = CLT_TRX_OFF;
			`CLT_MODE_RX: next_lin_trx = CLT_TRX_RX;
			default: next_lin_trx = CLT_TRX_ACTIVE;
		endcase
		if (evt.high_side_supply_undervoltage && !lin_supply_uv_bypass) begin
			next_lin_trx = CLT_TRX_OFF;
		end
		if (safety_hit && !lin_safety_offline_bypass) begin
			next_lin_trx = CLT_TRX_OFF;
		end
	end
	// registered transceiver controls
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ctl <= '{can_mode: CLT_TRX_OFF, lin_mode: CLT_TRX_OFF, default: 1'b0};
		end else begin
			o_ctl.can_mode <= next_can_trx;
			o_ctl.lin_mode <= next_lin_trx;
			o_ctl.lin_slow_slope <= lin_slope == `CLT_SLOPE_SLOW;
			o_ctl.lin_dominant_timeout_enable <= lin_dominant_timeout_enable;
			o_ctl.lin_short_protect_enable <= !lin_short_protect_disable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read images, unassigned bits zero
	logic [15:0] can_img;
	logic [15:0] lin_img;
	always_comb begin
		can_img = `CLT_RESET16;
		can_img[`CLT_CAN_THERM] = can_thermal_event_flag;
		can_img[`CLT_CAN_DTO] = can_dominant_timeout_flag;
		can_img[`CLT_CAN_BYP] = can_safety_offline_bypass;
		can_img[`CLT_CAN_ACT] = o_ctl.can_mode != CLT_TRX_OFF;
		can_img[`CLT_CAN_MODE_HI:`CLT_CAN_MODE_LO] = can_mode;
	end
	always_comb begin
		lin_img = `CLT_RESET16;
		lin_img[`CLT_LIN_THERM] = lin_thermal_event_flag;
		lin_img[`CLT_LIN_DTO] = lin_dominant_timeout_flag;
		lin_img[`CLT_LIN_SHORT] = lin_short_event_flag;
		lin_img[`CLT_LIN_DTO_EN] = lin_dominant_timeout_enable;
		lin_img[`CLT_LIN_SHORT_PROTECT_DISABLE_DIS] = lin_short_protect_disable;
		lin_img[`CLT_LIN_UV_BYP] = lin_supply_uv_bypass;
		lin_img[`CLT_LIN_BYP] = lin_safety_offline_bypass;
		lin_img[`CLT_LIN_SLOPE_HI:`CLT_LIN_SLOPE_LO] = lin_slope;
		lin_img[`CLT_LIN_MODE_HI:`CLT_LIN_MODE_LO] = lin_mode;
	end
	// read data register, loaded in the address phase
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hrdata <= '0;
		end else if (take && !i_hwrite) begin
			if (i_haddr[`CLT_ADDR_MSB:0] == `CLT_OFS_CAN) begin
				o_hrdata <= {16'h0000, can_img};
			end else if (i_haddr[`CLT_ADDR_MSB:0] == `CLT_OFS_LIN) begin
				o_hrdata <= {16'h0000, lin_img};
			end else begin
				o_hrdata <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_flag_set;
		@(posedge i_clk) disable iff (!i_resetn)
		evt.can_thermal |=> can_thermal_event_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("can thermal flag not set");
	property p_dto_set;
		@(posedge i_clk) disable iff (!i_resetn)
		evt.can_dominant |=> can_dominant_timeout_flag;
	endproperty
	a_dto_set: assert property (p_dto_set) else $error("can timeout flag not set");
	property p_w1c;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_lin && i_hwdata[`CLT_LIN_THERM] && !evt.lin_thermal) |=> !lin_thermal_event_flag;
	endproperty
	a_w1c: assert property (p_w1c) else $error("lin thermal flag not cleared");
	property p_w0_keep;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_lin && !i_hwdata[`CLT_LIN_THERM] && lin_thermal_event_flag) |=>
			lin_thermal_event_flag;
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");
	property p_lin_dto_gate;
		@(posedge i_clk) disable iff (!i_resetn)
		(!lin_dominant_timeout_enable && !lin_dominant_timeout_flag && !wr_lin)
			|=> !lin_dominant_timeout_flag;
	endproperty
	a_lin_dto_gate: assert property (p_lin_dto_gate) else $error("timeout set while off");
	property p_lin_short_protect_disable;
		@(posedge i_clk) disable iff (!i_resetn)
		(evt.lin_short && !lin_short_protect_disable) |=> lin_short_event_flag;
	endproperty
	a_lin_short_protect_disable: assert property (p_lin_short_protect_disable) else $error("short flag not set");
	property p_can_fs;
		@(posedge i_clk) disable iff (!i_resetn)
		(safety_hit && !can_safety_offline_bypass) |=> o_ctl.can_mode == CLT_TRX_OFF;
	endproperty
	a_can_fs: assert property (p_can_fs) else $error("can not forced offline");
	property p_lin_fs;
		@(posedge i_clk) disable iff (!i_resetn)
		(safety_hit && !lin_safety_offline_bypass) |=> o_ctl.lin_mode == CLT_TRX_OFF;
	endproperty
	a_lin_fs: assert property (p_lin_fs) else $error("lin not forced offline");
	property p_can_rx;
		@(posedge i_clk) disable iff (!i_resetn)
		(can_mode == `CLT_MODE_RX && !safety_hit) |=> o_ctl.can_mode == CLT_TRX_RX;
	endproperty
	a_can_rx: assert property (p_can_rx) else $error("can receive-only wrong");
	property p_lin_uv;
		@(posedge i_clk) disable iff (!i_resetn)
		(evt.high_side_supply_undervoltage && !lin_supply_uv_bypass) |=>
			o_ctl.lin_mode == CLT_TRX_OFF;
	endproperty
	a_lin_uv: assert property (p_lin_uv) else $error("lin on during undervoltage");
	property p_can_w1c;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_can && i_hwdata[`CLT_CAN_THERM] && !evt.can_thermal) |=>
			!can_thermal_event_flag;
	endproperty
	a_can_w1c: assert property (p_can_w1c) else $error("can thermal flag not cleared");
	property p_lin_therm_set;
		@(posedge i_clk) disable iff (!i_resetn)
		evt.lin_thermal |=> lin_thermal_event_flag;
	endproperty
	a_lin_therm_set: assert property (p_lin_therm_set) else $error("lin thermal not set");
	property p_lin_dto_set;
		@(posedge i_clk) disable iff (!i_resetn)
		lin_dto_set |=> lin_dominant_timeout_flag;
	endproperty
	a_lin_dto_set: assert property (p_lin_dto_set) else $error("lin timeout not set");
	property p_can_uv;
		@(posedge i_clk) disable iff (!i_resetn)
		(can_mode != `CLT_MODE_OFF && can_mode != `CLT_MODE_RX && evt.third_supply_undervoltage)
			|=> o_ctl.can_mode == CLT_TRX_OFF;
	endproperty
	a_can_uv: assert property (p_can_uv) else $error("can active in undervoltage");
	property p_can_act;
		@(posedge i_clk) disable iff (!i_resetn)
		(can_mode != `CLT_MODE_OFF && can_mode != `CLT_MODE_RX &&
			!evt.third_supply_undervoltage && (can_safety_offline_bypass || !safety_hit))
			|=> o_ctl.can_mode == CLT_TRX_ACTIVE;
	endproperty
	a_can_act: assert property (p_can_act) else $error("can not active");
	property p_lin_rx;
		@(posedge i_clk) disable iff (!i_resetn)
		(lin_mode == `CLT_MODE_RX && !safety_hit && !evt.high_side_supply_undervoltage)
			|=> o_ctl.lin_mode == CLT_TRX_RX;
	endproperty
	a_lin_rx: assert property (p_lin_rx) else $error("lin receive-only wrong");
	property p_lin_uv_keep;
		@(posedge i_clk) disable iff (!i_resetn)
		(lin_mode != `CLT_MODE_OFF && lin_mode != `CLT_MODE_RX && lin_supply_uv_bypass &&
			evt.high_side_supply_undervoltage && !safety_hit)
			|=> o_ctl.lin_mode == CLT_TRX_ACTIVE;
	endproperty
	a_lin_uv_keep: assert property (p_lin_uv_keep) else $error("lin dropped with bypass");
	property p_short_gate;
		@(posedge i_clk) disable iff (!i_resetn)
		(lin_short_protect_disable && !lin_short_event_flag) |=> !lin_short_event_flag;
	endproperty
	a_short_gate: assert property (p_short_gate) else $error("short set while off");
	property p_short_en;
		@(posedge i_clk) disable iff (!i_resetn)
		1'b1 |=> o_ctl.lin_short_protect_enable == !$past(lin_short_protect_disable);
	endproperty
	a_short_en: assert property (p_short_en) else $error("short enable wrong");
	property p_dto_en;
		@(posedge i_clk) disable iff (!i_resetn)
		1'b1 |=> o_ctl.lin_dominant_timeout_enable == $past(lin_dominant_timeout_enable);
	endproperty
	a_dto_en: assert property (p_dto_en) else $error("timeout enable wrong");
endmodule

/* File: tb/clt_far_side.sv */
`timescale 1ns/1ps
// far side: hazard and fail-safe pins seen from the transceivers and supplies
module clt_far_side (
	input wire logic i_clk,
	output clt_pkg::clt_evt_t o_evt
);
	import clt_pkg::*;
	// quiet level: active-low outputs high, all else low
	localparam clt_evt_t IDLE = 10'h005;
	initial o_evt = IDLE;
	// levels change just after a rising edge
	task automatic drive(input clt_evt_t v);
		@(posedge i_clk);
		o_evt <= v;
	endtask
	// event held long enough to pass the pin synchroniser, then quiet again
	task automatic pulse(input clt_evt_t v);
		drive(v);
		repeat (6) @(posedge i_clk);
		o_evt <= IDLE;
	endtask
endmodule

/* File: tb/test_clt_regs.sv */
`timescale 1ns/1ps
`include "clt_defines.svh"
module test_clt_regs;
	import clt_pkg::*;
	localparam logic [31:0] A_CAN = {24'h0, `CLT_OFS_CAN};
	localparam logic [31:0] A_LIN = {24'h0, `CLT_OFS_LIN};
	localparam logic [31:0] A_BAD = 32'h0000_0008;
	localparam clt_evt_t IDLE = 10'h005;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	clt_evt_t evt;
	clt_ctl_t ctl;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	clt_far_side far (.i_clk(i_clk), .o_evt(evt));
	clt_regs dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_can_thermal(evt.can_thermal), .i_can_dominant(evt.can_dominant),
		.i_lin_thermal(evt.lin_thermal), .i_lin_dominant(evt.lin_dominant),
		.i_lin_short(evt.lin_short),
		.i_third_supply_undervoltage(evt.third_supply_undervoltage),
		.i_high_side_supply_undervoltage(evt.high_side_supply_undervoltage),
		.i_reset_output_n(evt.reset_output_n), .i_limp_home_output(evt.limp_home_output),
		.i_failsafe_output_n(evt.failsafe_output_n), .o_ctl(ctl));
	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial forever #20 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= `CLT_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		hsize <= `CLT_HSIZE_WORD;
		do @(posedge i_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge i_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic chk_rd(input logic [31:0] a, exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		tests_run++;
		if (r !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t read %h expected %h", $time, r, exp);
		end
		tests_run++;
		if (hresp !== 1'b0) begin
			n_errors++;
			$display("CHECK FAILED t=%0t resp %h expected %h", $time, hresp, 1'b0);
		end
	endtask
	// controls looked at mid-cycle, then back on a rising edge for the next driver
	task automatic chk_ctl(input clt_ctl_t exp);
		@(negedge i_clk);
		tests_run++;
		if (ctl !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t ctl %h expected %h", $time, ctl, exp);
		end
		@(posedge i_clk);
	endtask
	// expected controls from can mode code and lin register contents
	function automatic clt_ctl_t ectl(input logic [1:0] cm, input logic [15:0] lr);
		ectl.can_mode = cm[1] ? CLT_TRX_ACTIVE : clt_trx_t'(cm);
		ectl.lin_mode = lr[14] ? CLT_TRX_ACTIVE : clt_trx_t'(lr[14:13]);
		ectl.lin_slow_slope = (lr[12:11] == `CLT_SLOPE_SLOW);
		ectl.lin_dominant_timeout_enable = lr[7];
		ectl.lin_short_protect_enable = ~lr[8];
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk_rd(A_CAN, 32'h0);
		chk_rd(A_LIN, 32'h0);
		chk_rd(A_BAD, 32'h0);
		chk_ctl(ectl(2'b00, 16'h0));
	endtask
	// every can mode code, with junk in unassigned and read-only bits
	task automatic t_can_modes();
		for (int m = 0; m < 4; m++) begin
			wr(A_CAN, 32'hffff_fcdc | (m << 8));
			settle(3);
			chk_ctl(ectl(m[1:0], 16'h0));
			chk_rd(A_CAN, {22'h0, m[1:0], (m != 0), 7'h0});
		end
	endtask
	// each fail-safe output, then the third supply undervoltage
	task automatic t_can_safety();
		clt_evt_t fs[3];
		fs = '{10'h001, 10'h007, 10'h004};
		for (int i = 0; i < 3; i++) begin
			wr(A_CAN, 32'h0200);
			far.drive(fs[i]);
			settle(8);
			chk_ctl(ectl(2'b00, 16'h0));
			chk_rd(A_CAN, 32'h0200);
			wr(A_CAN, 32'h0220);
			settle(8);
			chk_ctl(ectl(2'b10, 16'h0));
			far.drive(IDLE);
		end
		far.drive(10'h015);
		settle(8);
		chk_ctl(ectl(2'b00, 16'h0));
		far.drive(IDLE);
		wr(A_CAN, 32'h0);
	endtask
	task automatic t_can_flags();
		far.pulse(10'h305);
		settle(8);
		chk_rd(A_CAN, 32'h3);
		wr(A_CAN, 32'h0);
		chk_rd(A_CAN, 32'h3);
		wr(A_CAN, 32'h1);
		chk_rd(A_CAN, 32'h2);
		wr(A_CAN, 32'h2);
		chk_rd(A_CAN, 32'h0);
	endtask
	// lin fields, software keeps to slope codes 00 and 10
	task automatic t_lin_cfg();
		logic [15:0] tbl[6];
		tbl = '{16'h0080, 16'h0100, 16'h2200, 16'h5400, 16'h6000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			wr(A_LIN, {16'hffff, tbl[i] | 16'h8078});
			settle(3);
			chk_ctl(ectl(2'b00, tbl[i]));
			chk_rd(A_LIN, {16'h0, tbl[i]});
		end
	endtask
	task automatic t_lin_flags();
		wr(A_LIN, 32'h0080);
		far.pulse(10'h0e5);
		settle(8);
		chk_rd(A_LIN, 32'h0087);
		wr(A_LIN, 32'h0085);
		chk_rd(A_LIN, 32'h0082);
		wr(A_LIN, 32'h0082);
		chk_rd(A_LIN, 32'h0080);
		wr(A_LIN, 32'h0100);
		far.pulse(10'h065);
		settle(8);
		chk_rd(A_LIN, 32'h0100);
		wr(A_LIN, 32'h0);
	endtask
	// high-side undervoltage and fail-safe output, without and with bypass
	task automatic t_lin_safety();
		clt_evt_t hz[2];
		logic [15:0] byp[2];
		hz = '{10'h00d, 10'h004};
		byp = '{16'h0200, 16'h0400};
		for (int i = 0; i < 2; i++) begin
			wr(A_LIN, 32'h4000);
			far.drive(hz[i]);
			settle(8);
			chk_ctl(ectl(2'b00, 16'h0));
			wr(A_LIN, {16'h0, 16'h4000 | byp[i]});
			settle(8);
			chk_ctl(ectl(2'b00, 16'h4000 | byp[i]));
			far.drive(IDLE);
		end
		wr(A_LIN, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_can_modes();
		t_can_safety();
		t_can_flags();
		t_lin_cfg();
		t_lin_flags();
		t_lin_safety();
		conclude();
	end
endmodule
